// >>> shared/pps_pkg.sv
// pps_pkg: constants and carrier types for the pcm port strobe and mode select block
// assumes: sys_clk at 20 mhz, pcm bit clock well below half that rate
package pps_pkg;

   // clock and frame timing
   localparam int unsigned SYS_CLK_HZ       = 20000000;
   localparam int unsigned FRAME_PERIOD_US  = 125;
   localparam int unsigned FRAME_CYCLES     = (FRAME_PERIOD_US * (SYS_CLK_HZ / 1000000));
   localparam int unsigned BCLK_MIN_HZ      = 128000;
   localparam int unsigned BCLK_MAX_HZ      = 4096000;
   // frame lost if no line strobe for two frame periods
   localparam int unsigned FRAME_LOSS_CYCLES = 2 * FRAME_CYCLES;
   localparam int          FRAME_CNT_W      = 14;

   // strobe widths in bit times
   localparam logic [4:0]  STROBE_BITS_NARROW = 5'h08;
   localparam logic [4:0]  STROBE_BITS_WIDE   = 5'h10;

   // register offsets
   localparam logic [3:0]  ADDR_CTRL     = 4'h0;
   localparam logic [3:0]  ADDR_STATUS   = 4'h1;
   localparam logic [3:0]  ADDR_LINE_WID = 4'h2;
   localparam logic [3:0]  ADDR_MIC_WID  = 4'h3;
   localparam logic [3:0]  ADDR_MODE_TBL = 4'h4;
   localparam logic [3:0]  ADDR_RX_DATA  = 4'h5;

   // reset values
   localparam logic [7:0]  CTRL_RST      = 8'h00;
   localparam logic [7:0]  MODE_TBL_RST  = 8'he4;

   // ctrl field positions
   localparam int          CTRL_RX_EN_BIT = 0;

   typedef enum logic [1:0] {
      PPS_OP_SSI   = 2'b00,
      PPS_OP_FPBUS = 2'b01,
      PPS_OP_GCI   = 2'b10
   } pps_op_mode_t;

   typedef enum logic [1:0] {
      PPS_ST_IDLE  = 2'b00,
      PPS_ST_SHIFT = 2'b01,
      PPS_ST_DONE  = 2'b10
   } pps_shift_state_t;

   typedef struct packed {
      logic       line_strobe;
      logic       mic_strobe;
      logic       line_mode_b;
      logic       mic_mode_b;
      logic       frame_pulse;
      logic       bit_clock;
   } pps_pins_t;

   typedef struct packed {
      logic [1:0] line_mode;
      logic [1:0] mic_mode;
   } pps_chan_modes_t;

   typedef struct packed {
      logic        line_port;
      logic [15:0] word;
   } pps_word_t;

endpackage : pps_pkg

// >>> design/pps_top.sv
// pps_top: framing, operation detect and per-port mode decode for both pcm ports
// assumes: pins asynchronous to sys_clk, bit clock far below sys_clk, plain register port
// Overview of operation
// - line strobe high 8 or 16 bit times; line data shifts only then
// - mic strobe high 8 or 16 bit times; mic data moves only then
// - line strobe always present in strobe mode; it gives frame sync
// - fp bus or gci: line strobe pin is a static mode input with mode b
// - fp bus or gci: mic strobe pin is a static mode input with mode b
// - frame pulse tied low selects strobe mode; else low fp bus, high gci
`timescale 1ns/1ps
`default_nettype none
module pps_top (
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic                   line_port_strobe_or_mode_a,
   input  wire logic                   mic_port_strobe_or_mode_a,
   input  wire logic                   line_port_mode_b,
   input  wire logic                   mic_port_mode_b,
   input  wire logic                   frame_align_pulse_in,
   input  wire logic                   pcm_bit_clock_in,
   input  wire logic                   line_rx_in,
   input  wire logic                   mic_tx_in,
   output logic                        line_tx_out,
   output logic                        mic_rx_out,
   output logic                        simple_strobe_serial_mode,
   output logic [1:0]                  op_mode,
   output logic [1:0]                  line_chan_mode,
   output logic [1:0]                  mic_chan_mode,
   output logic                        word_valid,
   input  wire logic                   word_ready,
   output pps_pkg::pps_word_t          word_data,
   input  wire logic [3:0]             reg_addr,
   input  wire logic [15:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [15:0]                 reg_rdata
);

   // pin synchronisers
   pps_pkg::pps_pins_t pins_raw;
   pps_pkg::pps_pins_t pins_m_q;
   pps_pkg::pps_pins_t pins_s_q;
   logic [1:0]         data_m_q;
   logic [1:0]         data_s_q;
   pps_pkg::pps_pins_t pins_prev_q;

   assign pins_raw = '{line_strobe: line_port_strobe_or_mode_a, mic_strobe: mic_port_strobe_or_mode_a,
                       line_mode_b: line_port_mode_b, mic_mode_b: mic_port_mode_b,
                       frame_pulse: frame_align_pulse_in, bit_clock: pcm_bit_clock_in};

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pins_m_q    <= '0;
         pins_s_q    <= '0;
         pins_prev_q <= '0;
         data_m_q    <= 2'h0;
         data_s_q    <= 2'h0;
      end else begin
         pins_m_q    <= pins_raw;
         pins_s_q    <= pins_m_q;
         pins_prev_q <= pins_s_q;
         data_m_q    <= {line_rx_in, mic_tx_in};
         data_s_q    <= data_m_q;
      end
   end

   wire bclk_rise = pins_s_q.bit_clock & ~pins_prev_q.bit_clock;
   wire bclk_fall = ~pins_s_q.bit_clock & pins_prev_q.bit_clock;

   // operation detect: watch frame pulse pin over a two-frame window
   logic [pps_pkg::FRAME_CNT_W-1:0] fp_cnt_q;
   logic                            fp_seen_hi_q;
   logic                            fp_seen_lo_q;
   logic [1:0]                      op_mode_q;
   wire  fp_window_end = (fp_cnt_q == pps_pkg::FRAME_CNT_W'(pps_pkg::FRAME_LOSS_CYCLES - 1));
   // tied low = strobe mode; idle high with low pulses = fp bus; mostly low with high pulses = gci
   wire [1:0] op_mode_d = !fp_seen_hi_q ? pps_pkg::PPS_OP_SSI :
                          (fp_seen_lo_q && pins_s_q.frame_pulse) ? pps_pkg::PPS_OP_FPBUS :
                          pps_pkg::PPS_OP_GCI;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fp_cnt_q     <= '0;
         fp_seen_hi_q <= 1'b0;
         fp_seen_lo_q <= 1'b0;
         op_mode_q    <= pps_pkg::PPS_OP_SSI;
      end else if (fp_window_end) begin
         fp_cnt_q     <= '0;
         fp_seen_hi_q <= pins_s_q.frame_pulse;
         fp_seen_lo_q <= ~pins_s_q.frame_pulse;
         op_mode_q    <= op_mode_d;
      end else begin
         fp_cnt_q     <= fp_cnt_q + 1'b1;
         fp_seen_hi_q <= fp_seen_hi_q | pins_s_q.frame_pulse;
         fp_seen_lo_q <= fp_seen_lo_q | ~pins_s_q.frame_pulse;
      end
   end

   wire ssi_mode = (op_mode_q == pps_pkg::PPS_OP_SSI);
   assign simple_strobe_serial_mode = ssi_mode;
   assign op_mode = op_mode_q;

   // registers
   logic [7:0]  ctrl_q;
   logic [4:0]  line_wid_q;
   logic [4:0]  mic_wid_q;
   logic [7:0]  mode_tbl_q;
   logic [15:0] rdata_q;

   // mode decode: index {strobe pin, mode b pin} into 4 x 2-bit table
   wire [1:0] line_sel = {pins_s_q.line_strobe, pins_s_q.line_mode_b};
   wire [1:0] mic_sel  = {pins_s_q.mic_strobe, pins_s_q.mic_mode_b};
   wire [1:0] line_mode_lk = mode_tbl_q[{line_sel, 1'b0} +: 2];
   wire [1:0] mic_mode_lk  = mode_tbl_q[{mic_sel, 1'b0} +: 2];
   // mode b pins ignored in strobe mode
   assign line_chan_mode = ssi_mode ? 2'h0 : line_mode_lk;
   assign mic_chan_mode  = ssi_mode ? 2'h0 : mic_mode_lk;

   // frame sync and strobe-gated shifting
   logic                          frame_locked_q;
   logic [pps_pkg::FRAME_CNT_W-1:0] loss_cnt_q;
   pps_pkg::pps_shift_state_t     line_st_q;
   pps_pkg::pps_shift_state_t     mic_st_q;
   logic [4:0]                    line_bits_q;
   logic [4:0]                    mic_bits_q;
   logic [15:0]                   line_sr_q;
   logic [15:0]                   mic_sr_q;
   logic [15:0]                   line_tx_word_q;
   logic [15:0]                   mic_tx_word_q;
   logic                          line_tx_q;
   logic                          mic_rx_q;

   wire line_strobe_rise = pins_s_q.line_strobe & ~pins_prev_q.line_strobe;
   wire line_gate = ssi_mode & pins_s_q.line_strobe & frame_locked_q;
   wire mic_gate  = ssi_mode & pins_s_q.mic_strobe & frame_locked_q;
   wire line_last = (line_bits_q == line_wid_q - 5'h01);
   wire mic_last  = (mic_bits_q == mic_wid_q - 5'h01);
   wire line_cap  = line_gate & bclk_fall & (line_st_q == pps_pkg::PPS_ST_SHIFT);
   wire mic_cap   = mic_gate & bclk_fall & (mic_st_q == pps_pkg::PPS_ST_SHIFT);
   wire rx_en     = ctrl_q[pps_pkg::CTRL_RX_EN_BIT];

   // frame sync taken from line strobe; lost after two silent frames
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         frame_locked_q <= 1'b0;
         loss_cnt_q     <= '0;
      end else if (!ssi_mode) begin
         frame_locked_q <= 1'b0;
         loss_cnt_q     <= '0;
      end else if (line_strobe_rise) begin
         frame_locked_q <= 1'b1;
         loss_cnt_q     <= '0;
      end else if (loss_cnt_q == pps_pkg::FRAME_CNT_W'(pps_pkg::FRAME_LOSS_CYCLES)) begin
         frame_locked_q <= 1'b0;
      end else begin
         loss_cnt_q     <= loss_cnt_q + 1'b1;
      end
   end

   // line port: rx in and tx out
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         line_st_q   <= pps_pkg::PPS_ST_IDLE;
         line_bits_q <= 5'h00;
         line_sr_q   <= 16'h0000;
         line_tx_q   <= 1'b0;
      end else begin
         case (line_st_q)
            pps_pkg::PPS_ST_IDLE: begin
               line_bits_q <= 5'h00;
               // fresh word each window, no stale upper bits at width 8
               line_sr_q   <= 16'h0000;
               if (line_gate) begin
                  line_st_q <= pps_pkg::PPS_ST_SHIFT;
                  line_tx_q <= line_tx_word_q[15];
               end
            end
            pps_pkg::PPS_ST_SHIFT: begin
               if (!line_gate) begin
                  line_st_q <= pps_pkg::PPS_ST_IDLE;
               end else if (bclk_rise) begin
                  line_tx_q <= line_tx_word_q[4'(15 - line_bits_q)];
               end else if (line_cap) begin
                  line_sr_q   <= {line_sr_q[14:0], data_s_q[1]};
                  line_bits_q <= line_bits_q + 5'h01;
                  if (line_last) begin
                     line_st_q <= pps_pkg::PPS_ST_DONE;
                  end
               end
            end
            pps_pkg::PPS_ST_DONE: begin
               if (!pins_s_q.line_strobe) begin
                  line_st_q <= pps_pkg::PPS_ST_IDLE;
               end
            end
            default: line_st_q <= pps_pkg::PPS_ST_IDLE;
         endcase
      end
   end

   // mic port: tx in and rx out
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mic_st_q   <= pps_pkg::PPS_ST_IDLE;
         mic_bits_q <= 5'h00;
         mic_sr_q   <= 16'h0000;
         mic_rx_q   <= 1'b0;
      end else begin
         case (mic_st_q)
            pps_pkg::PPS_ST_IDLE: begin
               mic_bits_q <= 5'h00;
               mic_sr_q   <= 16'h0000;
               if (mic_gate) begin
                  mic_st_q <= pps_pkg::PPS_ST_SHIFT;
                  mic_rx_q <= mic_tx_word_q[15];
               end
            end
            pps_pkg::PPS_ST_SHIFT: begin
               if (!mic_gate) begin
                  mic_st_q <= pps_pkg::PPS_ST_IDLE;
               end else if (bclk_rise) begin
                  mic_rx_q <= mic_tx_word_q[4'(15 - mic_bits_q)];
               end else if (mic_cap) begin
                  mic_sr_q   <= {mic_sr_q[14:0], data_s_q[0]};
                  mic_bits_q <= mic_bits_q + 5'h01;
                  if (mic_last) begin
                     mic_st_q <= pps_pkg::PPS_ST_DONE;
                  end
               end
            end
            pps_pkg::PPS_ST_DONE: begin
               if (!pins_s_q.mic_strobe) begin
                  mic_st_q <= pps_pkg::PPS_ST_IDLE;
               end
            end
            default: mic_st_q <= pps_pkg::PPS_ST_IDLE;
         endcase
      end
   end

   // outputs driven only inside the strobe window
   assign line_tx_out = line_tx_q & line_gate;
   assign mic_rx_out  = mic_rx_q & mic_gate;

   // two-entry buffer for captured words
   pps_pkg::pps_word_t buf_q [2];
   logic [1:0]         buf_cnt_q;
   logic               buf_rd_q;
   logic               buf_wr_q;
   wire line_done = line_cap & line_last;
   wire mic_done  = mic_cap & mic_last;
   // line wins a same-cycle tie and the mic word is dropped; a lone word dropped only when buffer full
   wire push_req  = rx_en & (line_done | mic_done);
   wire buf_full  = (buf_cnt_q == 2'h2);
   wire pop       = word_valid & word_ready;
   // a pop in the same cycle frees a slot for the push
   wire push      = push_req & (~buf_full | pop);
   pps_pkg::pps_word_t push_word;
   assign push_word  = line_done ? '{line_port: 1'b1, word: {line_sr_q[14:0], data_s_q[1]}}
                                 : '{line_port: 1'b0, word: {mic_sr_q[14:0], data_s_q[0]}};
   assign word_valid = (buf_cnt_q != 2'h0);
   assign word_data  = buf_q[buf_rd_q];

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         buf_q[0]  <= '0;
         buf_q[1]  <= '0;
         buf_cnt_q <= 2'h0;
         buf_rd_q  <= 1'b0;
         buf_wr_q  <= 1'b0;
      end else begin
         if (push) begin
            buf_q[buf_wr_q] <= push_word;
            buf_wr_q        <= ~buf_wr_q;
         end
         if (pop) begin
            buf_rd_q <= ~buf_rd_q;
         end
         buf_cnt_q <= buf_cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

   // register port
   logic [15:0] overflow_cnt_q;
   wire wr_ctrl = reg_wr & (reg_addr == pps_pkg::ADDR_CTRL);
   wire wr_lwid = reg_wr & (reg_addr == pps_pkg::ADDR_LINE_WID);
   wire wr_mwid = reg_wr & (reg_addr == pps_pkg::ADDR_MIC_WID);
   wire wr_tbl  = reg_wr & (reg_addr == pps_pkg::ADDR_MODE_TBL);
   wire wr_tx   = reg_wr & (reg_addr == pps_pkg::ADDR_RX_DATA);
   // width writes other than 8 or 16 fall back to 8
   wire [4:0] wid_wr = (reg_wdata[4:0] == pps_pkg::STROBE_BITS_WIDE) ? pps_pkg::STROBE_BITS_WIDE
                                                                      : pps_pkg::STROBE_BITS_NARROW;
   wire [15:0] status_word = {5'h00, frame_locked_q, op_mode_q, line_chan_mode, mic_chan_mode,
                              word_valid, buf_full, line_st_q};
   wire [15:0] rdata_d = (reg_addr == pps_pkg::ADDR_CTRL)     ? {8'h00, ctrl_q} :
                         (reg_addr == pps_pkg::ADDR_STATUS)   ? status_word :
                         (reg_addr == pps_pkg::ADDR_LINE_WID) ? {11'h000, line_wid_q} :
                         (reg_addr == pps_pkg::ADDR_MIC_WID)  ? {11'h000, mic_wid_q} :
                         (reg_addr == pps_pkg::ADDR_MODE_TBL) ? {8'h00, mode_tbl_q} :
                         (reg_addr == pps_pkg::ADDR_RX_DATA)  ? overflow_cnt_q : 16'h0000;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_q         <= pps_pkg::CTRL_RST;
         line_wid_q     <= pps_pkg::STROBE_BITS_NARROW;
         mic_wid_q      <= pps_pkg::STROBE_BITS_NARROW;
         mode_tbl_q     <= pps_pkg::MODE_TBL_RST;
         rdata_q        <= 16'h0000;
         line_tx_word_q <= 16'h0000;
         mic_tx_word_q  <= 16'h0000;
         overflow_cnt_q <= 16'h0000;
      end else begin
         if (wr_ctrl) ctrl_q <= reg_wdata[7:0];
         if (wr_lwid) line_wid_q <= wid_wr;
         if (wr_mwid) mic_wid_q <= wid_wr;
         if (wr_tbl) mode_tbl_q <= reg_wdata[7:0];
         if (wr_tx) begin
            line_tx_word_q <= reg_wdata;
            mic_tx_word_q  <= reg_wdata;
         end
         if (push_req & ~push) overflow_cnt_q <= overflow_cnt_q + 16'h0001;
         rdata_q <= reg_rd ? rdata_d : 16'h0000;
      end
   end

   assign reg_rdata = rdata_q;

endmodule : pps_top
`default_nettype wire

// >>> tb/pps_checker.sv
// pps_checker: concurrent checks on the ports of pps_top, bound at the foot
// assumes: one sys_clk domain, rst asynchronous and active high
`timescale 1ns/1ps
`default_nettype none
module pps_checker (
   input wire logic              sys_clk,
   input wire logic              rst,
   input wire logic              line_port_strobe_or_mode_a,
   input wire logic              mic_port_strobe_or_mode_a,
   input wire logic              line_port_mode_b,
   input wire logic              mic_port_mode_b,
   input wire logic              frame_align_pulse_in,
   input wire logic              line_tx_out,
   input wire logic              mic_rx_out,
   input wire logic              simple_strobe_serial_mode,
   input wire logic [1:0]        op_mode,
   input wire logic [1:0]        line_chan_mode,
   input wire logic [1:0]        mic_chan_mode,
   input wire logic              word_valid,
   input wire logic              word_ready,
   input wire pps_pkg::pps_word_t word_data,
   input wire logic [3:0]        reg_addr,
   input wire logic [15:0]       reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [15:0]       reg_rdata
);
   logic [7:0] ls_q, ms_q, fp_q, tbl_q;
   logic [9:0] lp_q, mp_q;
   logic [1:0] tw_q;
   wire logic       tbl_wr = reg_wr && (reg_addr == pps_pkg::ADDR_MODE_TBL);
   wire logic [1:0] lp    = {line_port_strobe_or_mode_a, line_port_mode_b};
   wire logic [1:0] mp    = {mic_port_strobe_or_mode_a, mic_port_mode_b};
   // pins steady for five samples and no table write lately
   wire logic       l_quiet = (lp_q == {5{lp}}) && (tw_q == 2'b00);
   wire logic       m_quiet = (mp_q == {5{mp}}) && (tw_q == 2'b00);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         {ls_q, ms_q, fp_q, lp_q, mp_q, tw_q} <= '0;
         tbl_q <= pps_pkg::MODE_TBL_RST;
      end else begin
         ls_q <= {ls_q[6:0], line_port_strobe_or_mode_a};
         ms_q <= {ms_q[6:0], mic_port_strobe_or_mode_a};
         fp_q <= {fp_q[6:0], frame_align_pulse_in};
         lp_q <= {lp_q[7:0], lp};
         mp_q <= {mp_q[7:0], mp};
         tw_q <= {tw_q[0], tbl_wr};
         if (tbl_wr) tbl_q <= reg_wdata[7:0];
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_line_gate: assert property (simple_strobe_serial_mode && line_tx_out |-> |ls_q)
      else $error("line output high outside its strobe");
   a_mic_gate: assert property (simple_strobe_serial_mode && mic_rx_out |-> |ms_q)
      else $error("mic output high outside its strobe");
   a_ssi_chan_zero: assert property (simple_strobe_serial_mode |-> line_chan_mode == 2'b00 && mic_chan_mode == 2'b00)
      else $error("channel mode not zero in strobe mode");
   a_ssi_op_agree: assert property (simple_strobe_serial_mode == (op_mode == 2'b00))
      else $error("strobe mode flag and op mode disagree");
   a_ssi_entry_low: assert property ($rose(simple_strobe_serial_mode) |-> fp_q == 8'h00)
      else $error("strobe mode entered with frame pin active");
   a_line_decode: assert property (!simple_strobe_serial_mode && !$past(simple_strobe_serial_mode) && l_quiet
      |-> line_chan_mode == tbl_q[{lp, 1'b0} +: 2])
      else $error("line channel mode differs from table");
   a_mic_decode: assert property (!simple_strobe_serial_mode && !$past(simple_strobe_serial_mode) && m_quiet
      |-> mic_chan_mode == tbl_q[{mp, 1'b0} +: 2])
      else $error("mic channel mode differs from table");
   a_table_read: assert property (reg_rd && reg_addr == pps_pkg::ADDR_MODE_TBL |=> reg_rdata == {8'h00, tbl_q})
      else $error("mode table read back wrong");
   a_word_hold: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
      else $error("word dropped or changed while stalled");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside read answer");
   c_word_taken: cover property (word_valid && word_ready);
   c_fp_bus: cover property (op_mode == 2'b01);
   c_gci: cover property (op_mode == 2'b10);
endmodule : pps_checker
bind pps_top pps_checker pps_checker_i (.sys_clk, .rst, .line_port_strobe_or_mode_a, .mic_port_strobe_or_mode_a,
   .line_port_mode_b, .mic_port_mode_b, .frame_align_pulse_in, .line_tx_out, .mic_rx_out,
   .simple_strobe_serial_mode, .op_mode, .line_chan_mode, .mic_chan_mode, .word_valid, .word_ready,
   .word_data, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
`default_nettype wire

// >>> tb/pps_pcm_master.sv
// pps_pcm_master: behavioural pcm bus master making strobes, bit clock and data
// assumes: tasks are entered just after a rising sys_clk edge
`timescale 1ns/1ps
`default_nettype none
module pps_pcm_master (
   input  wire logic sys_clk,
   output var logic  line_strobe,
   output var logic  mic_strobe,
   output var logic  bit_clock,
   output var logic  line_data,
   output var logic  mic_data
);
   initial begin
      {line_strobe, mic_strobe, bit_clock, line_data, mic_data} = 5'h00;
   end
   // one window, msb first; data moves at bit clock rise, clock still outside
   task automatic window(input logic line, input int bits, input logic [15:0] w);
      int i;
      #10;
      if (line) line_strobe = 1'b1;
      else mic_strobe = 1'b1;
      for (i = bits - 1; i >= 0; i--) begin
         bit_clock = 1'b1;
         if (line) line_data = w[i];
         else mic_data = w[i];
         #200 bit_clock = 1'b0;
         #200;
      end
      line_strobe = 1'b0;
      mic_strobe = 1'b0;
      // released lines show the inverse of their last bit
      line_data = ~line_data;
      mic_data = ~mic_data;
   endtask : window
   task automatic frame(input int lb, input logic [15:0] lw, input int mb, input logic [15:0] mw);
      time t0;
      t0 = $time;
      window(1'b1, lb, lw);
      if (mb > 0) window(1'b0, mb, mw);
      #(t0 + 125000 - $time - 10);
   endtask : frame
   task automatic set_static(input logic a_line, input logic a_mic);
      #10;
      line_strobe = a_line;
      mic_strobe = a_mic;
   endtask : set_static
endmodule : pps_pcm_master
`default_nettype wire

// >>> tb/tb_pps_top.sv
// tb_pps_top: self-checking bench for pps_top with a pcm master model
// assumes: 20 mhz sys_clk, register answers one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module tb_pps_top;
   logic sys_clk, rst, line_port_mode_b, mic_port_mode_b, frame_align_pulse_in, word_ready, reg_wr, reg_rd;
   logic line_port_strobe_or_mode_a, mic_port_strobe_or_mode_a, pcm_bit_clock_in, line_rx_in, mic_tx_in;
   logic line_tx_out, mic_rx_out, simple_strobe_serial_mode, word_valid;
   logic [1:0] op_mode, line_chan_mode, mic_chan_mode;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   pps_pkg::pps_word_t word_data;
   int n_fail, n_compared;
   logic [15:0] line_seen, mic_seen;
   // serial outputs as the far side sees them at each bit clock fall
   always @(negedge pcm_bit_clock_in) begin
      if (line_port_strobe_or_mode_a) line_seen <= {line_seen[14:0], line_tx_out};
      if (mic_port_strobe_or_mode_a) mic_seen <= {mic_seen[14:0], mic_rx_out};
   end
   pps_top pps_top_i (.sys_clk, .rst, .line_port_strobe_or_mode_a, .mic_port_strobe_or_mode_a, .line_port_mode_b,
      .mic_port_mode_b, .frame_align_pulse_in, .pcm_bit_clock_in, .line_rx_in, .mic_tx_in, .line_tx_out,
      .mic_rx_out, .simple_strobe_serial_mode, .op_mode, .line_chan_mode, .mic_chan_mode, .word_valid,
      .word_ready, .word_data, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   pps_pcm_master pps_pcm_master_i (.sys_clk, .line_strobe(line_port_strobe_or_mode_a),
      .mic_strobe(mic_port_strobe_or_mode_a), .bit_clock(pcm_bit_clock_in), .line_data(line_rx_in),
      .mic_data(mic_tx_in));
   task automatic summarize();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      d = reg_rdata;
   endtask : rd
   task automatic pop(input logic [16:0] exp);
      int k;
      for (k = 0; k < 400 && word_valid !== 1'b1; k++) @(posedge sys_clk);
      check(word_data, exp);
      word_ready <= 1'b1;
      @(posedge sys_clk);
      word_ready <= 1'b0;
      @(posedge sys_clk);
   endtask : pop
   task automatic wait_op(input logic [1:0] m);
      int k;
      for (k = 0; k < 12000 && op_mode !== m; k++) begin
         @(posedge sys_clk);
         if (m == 2'b01) frame_align_pulse_in <= (k % 64) != 0;
      end
      check(17'(op_mode), 17'(m));
      if (op_mode !== m) summarize();
   endtask : wait_op
   task automatic settle(input logic [1:0] le, input logic [1:0] me);
      int k;
      for (k = 0; k < 12 && {line_chan_mode, mic_chan_mode} !== {le, me}; k++) @(posedge sys_clk);
      check(17'(line_chan_mode), 17'(le));
      check(17'(mic_chan_mode), 17'(me));
   endtask : settle
   task automatic test_reset();
      logic [15:0] d;
      check(17'(simple_strobe_serial_mode), 17'h1);
      rd(pps_pkg::ADDR_CTRL, d);
      check(17'(d), 17'(pps_pkg::CTRL_RST));
      rd(pps_pkg::ADDR_MODE_TBL, d);
      check(17'(d), 17'(pps_pkg::MODE_TBL_RST));
      wr(pps_pkg::ADDR_LINE_WID, 16'h000c);
      rd(pps_pkg::ADDR_LINE_WID, d);
      check(17'(d), 17'(pps_pkg::STROBE_BITS_NARROW));
      rd(4'hf, d);
      check(17'(d), 17'h0);
   endtask : test_reset
   task automatic test_words();
      logic [15:0] d;
      wr(pps_pkg::ADDR_CTRL, 16'h0001);
      wr(pps_pkg::ADDR_MIC_WID, 16'h0010);
      wr(pps_pkg::ADDR_RX_DATA, 16'h96e1);
      pps_pcm_master_i.frame(8, 16'h00a5, 16, 16'hc3e1);
      @(posedge sys_clk);
      pps_pcm_master_i.frame(8, 16'h005a, 0, 16'h0000);
      @(posedge sys_clk);
      rd(pps_pkg::ADDR_STATUS, d);
      check(17'(d[10]), 17'h1);
      check(17'(d[3:2]), 17'h3);
      rd(pps_pkg::ADDR_RX_DATA, d);
      check(17'(d), 17'h1);
      check(17'(line_seen[7:0]), 17'h96);
      check(17'(mic_seen), 17'h96e1);
      pop({1'b1, 16'h00a5});
      pop({1'b0, 16'hc3e1});
      pps_pcm_master_i.frame(8, 16'h003c, 0, 16'h0000);
      pop({1'b1, 16'h003c});
      check(17'(word_valid), 17'h0);
   endtask : test_words
   task automatic test_decode();
      int i;
      logic [7:0] t;
      t = pps_pkg::MODE_TBL_RST;
      frame_align_pulse_in <= 1'b1;
      wait_op(2'b10);
      for (i = 0; i < 4; i++) begin
         line_port_mode_b <= i[0];
         mic_port_mode_b <= ~i[0];
         pps_pcm_master_i.set_static(i[1], ~i[1]);
         settle(t[2 * i +: 2], t[2 * (3 - i) +: 2]);
      end
      wr(pps_pkg::ADDR_MODE_TBL, 16'h001b);
      settle(2'b00, 2'b11);
      wait_op(2'b01);
      frame_align_pulse_in <= 1'b0;
      line_port_mode_b <= 1'b0;
      mic_port_mode_b <= 1'b0;
      pps_pcm_master_i.set_static(1'b0, 1'b0);
      wait_op(2'b00);
      check(17'(simple_strobe_serial_mode), 17'h1);
      settle(2'b00, 2'b00);
   endtask : test_decode
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      rst = 1'b1;
      {line_port_mode_b, mic_port_mode_b, frame_align_pulse_in, word_ready, reg_wr, reg_rd} = 6'h00;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      test_reset();
      test_words();
      test_decode();
      summarize();
   end
endmodule : tb_pps_top
`default_nettype wire
